/* rtl/fcd_dma.sv */
// fcd_dma: four-channel dma engine with one memory bus master port
// assumes a bus slave that answers each mem_req with a one-cycle mem_ack
// How it works
// [RULE1] four channels, 32-bit addresses
// [RULE2] units of 8, 16, 32 bits or 16 bytes
// [RULE3] 16-byte unit: four word reads, four writes
// [RULE4] up to 16,777,216 units per programming
// [RULE5] direct dual mode: one read, one write
// [RULE6] channel 3 indirect: fetch address, then transfer
// [RULE7] single mode: strobe one side, address other
// [RULE8] channel 2 reloads source every four units
// [RULE9] channels 0,1 take edge or low-level requests
// [RULE10] every channel accepts peripheral requests
// [RULE11] auto mode requests itself
// [RULE12] cycle-steal releases bus, burst keeps it
// [RULE13] fixed or round-robin, granted channel goes last
// [RULE14] interrupt when a channel completes its count
// [RULE15] strobe to external device on channels 0,1
// [RULE16] request-taken pulse on channels 0,1
// [RULE17] count 1 means one, 0 means maximum
// [RULE18] 16-byte unit counts one; pointers show next
// [RULE19] channel stops and flags done at zero
// [RULE20] one channel granted at a time by priority
`timescale 1ns/10ps
module fcd_dma (
  // clock and reset
  input  wire logic                                      core_clk,
  input  wire logic                                      rst,
  // global configuration
  input  wire logic                                      burst_mode,
  input  wire logic                                      rr_mode,
  // channel programming
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_start,
  input  wire logic [fcd_pkg::NUM_CH-1:0][31:0]          ch_src_init,
  input  wire logic [fcd_pkg::NUM_CH-1:0][31:0]          ch_dst_init,
  input  wire logic [fcd_pkg::NUM_CH-1:0][23:0]          ch_count_init,
  input  wire logic [fcd_pkg::NUM_CH-1:0][1:0]           ch_size,
  input  wire logic [fcd_pkg::NUM_CH-1:0][1:0]           ch_req_sel,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_src_inc,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_dst_inc,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_single,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_single_to_mem,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_irq_en,
  input  wire logic [fcd_pkg::NUM_CH-1:0]                ch_done_clear,
  input  wire logic                                      ch2_reload,
  input  wire logic                                      ch3_indirect,
  input  wire logic [fcd_pkg::EXT_CH_NUM-1:0]            ext_edge_mode,
  // peripheral requests
  input  wire logic [fcd_pkg::NUM_CH-1:0]                periph_req,
  output logic [fcd_pkg::NUM_CH-1:0]                     periph_ack,
  // external device pins
  input  wire logic                                      ext_xfer_request_ch0_n,
  input  wire logic                                      ext_xfer_request_ch1_n,
  output logic                                           xfer_strobe_ch0,
  output logic                                           xfer_strobe_ch1,
  output logic                                           request_taken_ch0,
  output logic                                           request_taken_ch1,
  // memory bus master
  output logic                                           mem_req,
  output logic                                           mem_we,
  output logic [1:0]                                     mem_size,
  output logic [31:0]                                    mem_addr,
  output logic [31:0]                                    mem_wdata,
  input  wire logic                                      mem_ack,
  input  wire logic [31:0]                               mem_rdata,
  output logic                                           bus_hold,
  // status
  output logic [fcd_pkg::NUM_CH-1:0]                     ch_active,
  output logic [fcd_pkg::NUM_CH-1:0]                     ch_done,
  output logic [fcd_pkg::NUM_CH-1:0][23:0]               remaining_count,
  output logic [fcd_pkg::NUM_CH-1:0][31:0]               source_pointer,
  output logic [fcd_pkg::NUM_CH-1:0][31:0]               destination_pointer,
  output logic                                           dma_irq
);

  localparam int NCH = fcd_pkg::NUM_CH;

  fcd_pkg::fcd_state_t state_q;
  fcd_pkg::fcd_state_t state_d;

  logic [NCH-1:0][31:0]           src_q, dst_q;
  logic [NCH-1:0][23:0]           cnt_q;
  logic [NCH-1:0]                 active_q, done_q, req_vec;
  logic [31:0]                    orig_src_q, ind_addr_q, step, f_out_data;
  logic [1:0]                     rld_cnt_q, cur_q, beat_q, prio_q, pick, gnt_ch, csize;
  logic [fcd_pkg::EXT_CH_NUM-1:0] ext_pend, ext_n, ext_take;
  logic                           any_req, grant, blk, last_beat, indirect, unit_end, last_unit, keep_bus;
  logic                           f_in_ready, f_out_valid, rd_ack, wr_ack, ind_ack, sgl_ack;

  assign ext_n = {ext_xfer_request_ch1_n, ext_xfer_request_ch0_n};
  for (genvar e = 0; e < fcd_pkg::EXT_CH_NUM; e++) begin : g_ext
    assign ext_take[e] = grant & (gnt_ch == 2'(e)) & (ch_req_sel[e] == fcd_pkg::RQ_EXT);
    fcd_req_det u_det (
      .core_clk  (core_clk),
      .rst       (rst),
      .req_n     (ext_n[e]),
      .edge_mode (ext_edge_mode[e]),
      .take      (ext_take[e]),
      .pending   (ext_pend[e])
    ); // RULE9
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      unique case (ch_req_sel[i])
        fcd_pkg::RQ_AUTO:   req_vec[i] = active_q[i]; // RULE11
        fcd_pkg::RQ_PERIPH: req_vec[i] = active_q[i] & periph_req[i]; // RULE10
        fcd_pkg::RQ_EXT:    req_vec[i] = active_q[i] & (i < fcd_pkg::EXT_CH_NUM) &
                                         ext_pend[i % fcd_pkg::EXT_CH_NUM]; // RULE9
        default:            req_vec[i] = 1'b0;
      endcase
    end
  end

  // priority pick, fixed from channel 0 or rotating from prio_q
  always_comb begin
    logic [1:0] idx;
    logic       found;
    idx   = '0;
    found = 1'b0;
    pick  = '0;
    for (int k = 0; k < NCH; k++) begin
      idx = (rr_mode ? prio_q : 2'h0) + 2'(k); // RULE13
      if (!found && req_vec[idx]) begin
        found = 1'b1;
        pick  = idx;
      end
    end
    any_req = found;
  end
  assign csize     = ch_size[cur_q];
  assign blk       = (csize == fcd_pkg::SZ_BLK16);
  assign step      = (csize == fcd_pkg::SZ_BYTE) ? fcd_pkg::STEP_BYTE :
                     (csize == fcd_pkg::SZ_HALF) ? fcd_pkg::STEP_HALF : fcd_pkg::STEP_WORD;
  assign last_beat = ~blk | (beat_q == fcd_pkg::BLK_LAST_BEAT);
  assign indirect  = ch3_indirect & (cur_q == 2'(fcd_pkg::INDIRECT_CH));
  assign rd_ack    = (state_q == fcd_pkg::ST_RD) & mem_ack;
  assign wr_ack    = (state_q == fcd_pkg::ST_WR) & mem_ack;
  assign ind_ack   = (state_q == fcd_pkg::ST_IND) & mem_ack;
  assign sgl_ack   = (state_q == fcd_pkg::ST_SGL) & mem_ack;
  assign unit_end  = (wr_ack & last_beat) | sgl_ack;
  assign last_unit = (cnt_q[cur_q] == fcd_pkg::CNT_ONE); // RULE17
  assign keep_bus  = unit_end & ~last_unit & burst_mode & req_vec[cur_q]; // RULE12
  assign grant     = ((state_q == fcd_pkg::ST_IDLE) & any_req) | keep_bus; // RULE20
  assign gnt_ch    = (state_q == fcd_pkg::ST_IDLE) ? pick : cur_q;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fcd_pkg::ST_IDLE: begin
        if (any_req) begin
          if (ch_single[pick]) begin
            state_d = fcd_pkg::ST_SGL; // RULE7
          end else if (ch3_indirect && pick == 2'(fcd_pkg::INDIRECT_CH)) begin
            state_d = fcd_pkg::ST_IND; // RULE6
          end else begin
            state_d = fcd_pkg::ST_RD; // RULE5
          end
        end
      end
      fcd_pkg::ST_IND: begin
        if (ind_ack && beat_q == fcd_pkg::IND_LAST_BEAT) begin
          state_d = fcd_pkg::ST_RD;
        end
      end
      fcd_pkg::ST_RD: begin
        if (mem_ack && last_beat) begin
          state_d = fcd_pkg::ST_WR; // RULE3
        end
      end
      fcd_pkg::ST_WR, fcd_pkg::ST_SGL: begin
        if (keep_bus) begin
          state_d = ch_single[cur_q] ? fcd_pkg::ST_SGL :
                    (indirect ? fcd_pkg::ST_IND : fcd_pkg::ST_RD);
        end else if (unit_end) begin
          state_d = fcd_pkg::ST_IDLE; // RULE12
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= fcd_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_q  <= '0;
      prio_q <= '0;
    end else if (grant) begin
      cur_q  <= gnt_ch;
      prio_q <= gnt_ch + 2'h1; // RULE13
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      beat_q <= '0;
    end else if (ind_ack || ((rd_ack || wr_ack) && blk)) begin
      beat_q <= ((ind_ack && beat_q == fcd_pkg::IND_LAST_BEAT) || (!ind_ack && last_beat)) ? '0 :
                beat_q + fcd_pkg::BEAT_ONE; // RULE3
    end
  end
  // indirect address fetched as two halfword cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ind_addr_q <= '0;
    end else if (ind_ack) begin
      if (beat_q == '0) begin
        ind_addr_q[31:16] <= mem_rdata[15:0];
      end else begin
        ind_addr_q[15:0] <= mem_rdata[15:0];
      end
    end else if (rd_ack && indirect) begin
      ind_addr_q <= ind_addr_q + step;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_q      <= '0;
      dst_q      <= '0;
      cnt_q      <= '0;
      orig_src_q <= '0;
      rld_cnt_q  <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_start[i]) begin
          src_q[i] <= ch_src_init[i]; // RULE1
          dst_q[i] <= ch_dst_init[i];
          cnt_q[i] <= ch_count_init[i]; // RULE4
        end
      end
      if (ch_start[fcd_pkg::RELOAD_CH]) begin
        orig_src_q <= ch_src_init[fcd_pkg::RELOAD_CH];
        rld_cnt_q  <= '0;
      end
      if (ind_ack && beat_q == fcd_pkg::IND_LAST_BEAT) begin
        src_q[cur_q] <= src_q[cur_q] + fcd_pkg::STEP_WORD; // RULE6
      end
      if (((rd_ack && !indirect) || (sgl_ack && !ch_single_to_mem[cur_q])) && ch_src_inc[cur_q]) begin
        src_q[cur_q] <= src_q[cur_q] + step; // RULE18
      end
      if ((wr_ack || (sgl_ack && ch_single_to_mem[cur_q])) && ch_dst_inc[cur_q]) begin
        dst_q[cur_q] <= dst_q[cur_q] + step; // RULE18
      end
      if (unit_end) begin
        cnt_q[cur_q] <= cnt_q[cur_q] - fcd_pkg::CNT_ONE; // RULE18
        if (ch2_reload && cur_q == 2'(fcd_pkg::RELOAD_CH)) begin
          rld_cnt_q <= rld_cnt_q + fcd_pkg::BEAT_ONE;
          if (rld_cnt_q == fcd_pkg::RELOAD_LAST) begin
            src_q[cur_q] <= orig_src_q; // RULE8
          end
        end
      end
    end
  end
  // run and completion flags, a completion wins over its clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      active_q <= '0;
      done_q   <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (unit_end && last_unit && cur_q == 2'(i)) begin
          active_q[i] <= 1'b0; // RULE19
          done_q[i]   <= 1'b1;
        end else begin
          if (ch_start[i]) begin
            active_q[i] <= 1'b1;
          end
          if (ch_done_clear[i]) begin
            done_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // read data parks here until the write cycle
  fcd_fifo #(
    .WIDTH (fcd_pkg::DATA_W),
    .DEPTH (fcd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rd_ack),
    .in_ready  (f_in_ready),
    .in_data   (mem_rdata),
    .out_valid (f_out_valid),
    .out_ready (wr_ack),
    .out_data  (f_out_data)
  );
  always_comb begin
    mem_req  = 1'b0;
    mem_we   = 1'b0;
    mem_size = blk ? fcd_pkg::SZ_WORD : csize; // RULE2
    mem_addr = src_q[cur_q];
    unique case (state_q)
      fcd_pkg::ST_IDLE: mem_req = 1'b0;
      fcd_pkg::ST_IND: begin
        mem_req  = 1'b1;
        mem_size = fcd_pkg::SZ_HALF;
        mem_addr = (beat_q == '0) ? src_q[cur_q] : src_q[cur_q] + fcd_pkg::STEP_HALF;
      end
      fcd_pkg::ST_RD: begin
        mem_req  = f_in_ready;
        mem_addr = indirect ? ind_addr_q : src_q[cur_q];
      end
      fcd_pkg::ST_WR: begin
        mem_req  = f_out_valid;
        mem_we   = 1'b1;
        mem_addr = dst_q[cur_q];
      end
      fcd_pkg::ST_SGL: begin
        mem_req  = 1'b1;
        mem_we   = ch_single_to_mem[cur_q]; // RULE7
        mem_addr = ch_single_to_mem[cur_q] ? dst_q[cur_q] : src_q[cur_q];
      end
    endcase
  end
  assign mem_wdata = f_out_data;
  assign bus_hold  = (state_q != fcd_pkg::ST_IDLE);
  assign xfer_strobe_ch0   = bus_hold & (cur_q == 2'h0) & (ch_req_sel[0] == fcd_pkg::RQ_EXT); // RULE15
  assign xfer_strobe_ch1   = bus_hold & (cur_q == 2'h1) & (ch_req_sel[1] == fcd_pkg::RQ_EXT); // RULE15
  assign request_taken_ch0 = ext_take[0]; // RULE16
  assign request_taken_ch1 = ext_take[1]; // RULE16
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      periph_ack[i] = grant & (gnt_ch == 2'(i)) & (ch_req_sel[i] == fcd_pkg::RQ_PERIPH);
    end
  end
  assign ch_active           = active_q;
  assign ch_done             = done_q;
  assign remaining_count     = cnt_q;
  assign source_pointer      = src_q;
  assign destination_pointer = dst_q;
  assign dma_irq             = |(done_q & ch_irq_en); // RULE14

endmodule // fcd_dma

/* rtl/fcd_pkg.sv */
// fcd_pkg: constants, codes and state type of the four-channel dma engine
// assumes one core clock, synchronous active-high reset
package fcd_pkg;

  localparam int NUM_CH      = 4;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int CNT_W       = 24;
  localparam int FIFO_DEPTH  = 8;
  localparam int EXT_CH_NUM  = 2;
  localparam int RELOAD_CH   = 2;
  localparam int INDIRECT_CH = 3;

  // transfer unit codes; all but SZ_BLK16 are also the bus size codes
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_HALF  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_BLK16 = 2'h3;

  // request source codes
  localparam logic [1:0] RQ_AUTO   = 2'h0;
  localparam logic [1:0] RQ_PERIPH = 2'h1;
  localparam logic [1:0] RQ_EXT    = 2'h2;

  // address steps
  localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0004;

  // beat counts
  localparam logic [1:0] BLK_LAST_BEAT = 2'h3;
  localparam logic [1:0] IND_LAST_BEAT = 2'h1;
  localparam logic [1:0] RELOAD_LAST   = 2'h3;
  localparam logic [1:0] BEAT_ONE      = 2'h1;

  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_IND  = 5'h02,
    ST_RD   = 5'h04,
    ST_WR   = 5'h08,
    ST_SGL  = 5'h10
  } fcd_state_t;

endpackage

/* rtl/fcd_req_det.sv */
// fcd_req_det: active-low external request detector, edge or level
// assumes the request pin is synchronous to core_clk
`timescale 1ns/10ps
module fcd_req_det (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // request pin and mode
  input  wire logic req_n,
  input  wire logic edge_mode,
  // grant side
  input  wire logic take,
  output logic      pending
);

  logic prev_q;
  logic edge_pend_q;
  logic fall;

  assign fall    = prev_q & ~req_n;
  assign pending = edge_mode ? edge_pend_q : ~req_n;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= req_n;
    end
  end

  // a new falling edge wins over the take
  always_ff @(posedge core_clk) begin
    if (rst) begin
      edge_pend_q <= 1'b0;
    end else if (fall) begin
      edge_pend_q <= 1'b1;
    end else if (take) begin
      edge_pend_q <= 1'b0;
    end
  end

endmodule // fcd_req_det

/* rtl/fcd_fifo.sv */
// fcd_fifo: small data fifo with registered read data
// assumes valid/ready handshakes on both sides
`timescale 1ns/10ps
module fcd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             load;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign push     = in_valid & in_ready;
  assign load     = (cnt_q != '0) & (~out_valid | out_ready);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(load);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rp_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // fcd_fifo

/* bench/fcd_mem.sv */
// fcd_mem: memory slave for the engine bus, one-cycle ack after a set wait
// assumes requests stand until acknowledged
`timescale 1ns/10ps
module fcd_mem (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // bus from the engine
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  // answer side
  input  wire logic [3:0]  slow,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [3:0] wait_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      wait_q    <= 4'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && wait_q >= slow) begin
      mem_ack   <= 1'b1;
      wait_q    <= 4'h0;
      // read data carries its own address in the low half
      mem_rdata <= mem_we ? ~mem_rdata : {~mem_addr[15:0], mem_addr[15:0]};
    end else begin
      mem_ack   <= 1'b0;
      wait_q    <= mem_req ? wait_q + 4'h1 : 4'h0;
      // idle data never holds the last value
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // fcd_mem

/* bench/fcd_dma_chk.sv */
// fcd_dma_chk: port-level properties of the dma engine
// assumes binding to fcd_dma, one clock, synchronous reset
`timescale 1ns/10ps
module fcd_dma_chk (
  // clock and reset
  input wire logic                             core_clk,
  input wire logic                             rst,
  // observed ports
  input wire logic [fcd_pkg::NUM_CH-1:0]       ch_irq_en,
  input wire logic [fcd_pkg::NUM_CH-1:0]       periph_ack,
  input wire logic                             xfer_strobe_ch0,
  input wire logic                             request_taken_ch0,
  input wire logic                             request_taken_ch1,
  input wire logic                             mem_req,
  input wire logic                             mem_we,
  input wire logic [31:0]                      mem_addr,
  input wire logic                             mem_ack,
  input wire logic                             bus_hold,
  input wire logic [fcd_pkg::NUM_CH-1:0]       ch_active,
  input wire logic [fcd_pkg::NUM_CH-1:0]       ch_done,
  input wire logic [fcd_pkg::NUM_CH-1:0][23:0] remaining_count,
  input wire logic                             dma_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  req_stands_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("bus request changed before ack");
  taken_pulse_a: assert property (request_taken_ch0 |=> !request_taken_ch0)
    else $error("request taken longer than one cycle");
  strobe_follows_a: assert property (request_taken_ch0 |=> xfer_strobe_ch0)
    else $error("strobe missing after grant");
  strobe_owns_a: assert property (xfer_strobe_ch0 |-> bus_hold)
    else $error("strobe without bus");
  one_grant_a: assert property ($onehot0({periph_ack, request_taken_ch0, request_taken_ch1}))
    else $error("two grants at once");
  req_holds_a: assert property (mem_req |-> bus_hold)
    else $error("bus cycle without bus hold");
  irq_on_done_a: assert property ($rose(ch_done[0]) && ch_irq_en[0] |-> dma_irq)
    else $error("no interrupt at completion");
  stop_flags_done_a: assert property ($fell(ch_active[0]) |-> ch_done[0] && remaining_count[0] == 24'h00_0000)
    else $error("channel stopped without done at zero");
  done_after_ack_a: assert property ($rose(ch_done[0]) |-> $past(mem_ack))
    else $error("done without final ack");
  cover property (request_taken_ch1);
  cover property ($rose(dma_irq));
  cover property (|periph_ack);
endmodule // fcd_dma_chk

bind fcd_dma fcd_dma_chk fcd_dma_chk_i (.*);

/* bench/fcd_dma_tb.sv */
// fcd_dma_tb: directed tests of the dma engine against a memory model
// assumes fcd_pkg, fcd_dma, fcd_mem and the bound checker are compiled
`timescale 1ns/10ps
module fcd_dma_tb;
  logic             core_clk, rst, burst_mode, rr_mode, ch2_reload, ch3_indirect, mem_ack, mem_req, mem_we;
  logic             ext_xfer_request_ch0_n, ext_xfer_request_ch1_n, bus_hold, dma_irq;
  logic             xfer_strobe_ch0, xfer_strobe_ch1, request_taken_ch0, request_taken_ch1;
  logic [3:0]       ch_start, ch_src_inc, ch_dst_inc, ch_single, ch_single_to_mem, ch_irq_en, ch_done_clear;
  logic [3:0]       periph_req, periph_ack, ch_active, ch_done, slow;
  logic [3:0][31:0] ch_src_init, ch_dst_init, source_pointer, destination_pointer;
  logic [3:0][23:0] ch_count_init, remaining_count;
  logic [3:0][1:0]  ch_size, ch_req_sel;
  logic [1:0]       ext_edge_mode, mem_size;
  logic [31:0]      mem_addr, mem_wdata, mem_rdata;
  logic [64:0]      q[$];
  int               miscompares, n_compared, cyc_n, tk, sb, pk, sz, i, k;

  fcd_dma fcd_dma_i (.*);
  fcd_mem fcd_mem_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // bus log and event counts, sampled before the edge updates
  always @(posedge core_clk) begin
    if (mem_req && mem_ack) q.push_back({mem_we, mem_addr, mem_wdata});
    tk += request_taken_ch0 + request_taken_ch1;
    sb += xfer_strobe_ch0 + xfer_strobe_ch1;
    pk += periph_ack[2];
    sz += mem_req && mem_ack && mem_size == fcd_pkg::SZ_BYTE;
    cyc_n++;
    if (cyc_n == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  function automatic logic [31:0] fd(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cyc(input logic we, input logic [31:0] a, d, input bit cd);
    logic [64:0] e;
    e = q.size() ? q.pop_front() : 'x;
    chk(32'(we), 32'(e[64]));
    chk(a, e[63:32]);
    if (cd) chk(d, e[31:0]);
  endtask

  task automatic go(input int c, input logic [31:0] s, d, input logic [23:0] n, input logic [1:0] sz, rq);
    ch_src_init[c] = s;
    ch_dst_init[c] = d;
    ch_count_init[c] = n;
    ch_size[c] = sz;
    ch_req_sel[c] = rq;
    q.delete();
    ch_start[c] = 1'b1;
    ch_done_clear[c] = 1'b1;
    @(negedge core_clk);
    ch_start = 4'h0;
    ch_done_clear = 4'h0;
  endtask

  task automatic wdone(input logic [3:0] m);
    for (k = 0; k < 400 && (ch_done & m) !== m; k++) @(negedge core_clk);
    chk(32'(m), 32'(ch_done & m));
  endtask

  // two auto channels at once; ord bit i names the channel of unit i
  task automatic pri(input logic b, r, input logic [3:0] ord);
    int n[2];
    logic [31:0] s;
    {burst_mode, rr_mode} = {b, r};
    n = '{0, 0};
    for (i = 0; i < 2; i++)
      go(i, 32'h0000_0100 << i, 32'h0000_1000 << i, 24'h00_0002, fcd_pkg::SZ_WORD, fcd_pkg::RQ_AUTO);
    wdone(4'h3);
    for (i = 0; i < 4; i++) begin
      s = (32'h0000_0100 << ord[i]) + 4 * n[ord[i]];
      cyc(1'b0, s, 0, 0);
      cyc(1'b1, (32'h0000_1000 << ord[i]) + 4 * n[ord[i]], fd(s), 1);
      n[ord[i]]++;
    end
  endtask

  initial begin
    rst = 1'b1;
    {burst_mode, rr_mode, ch2_reload, ch3_indirect, ch_start, ch_single, ch_single_to_mem} = '0;
    {ch_done_clear, periph_req, ext_edge_mode, slow, ch_size, ch_req_sel} = '0;
    {ch_src_init, ch_dst_init, ch_count_init} = '0;
    {ext_xfer_request_ch0_n, ext_xfer_request_ch1_n} = 2'h3;
    {ch_irq_en, ch_src_inc, ch_dst_inc} = 12'hFFF;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    go(0, 32'h0000_1000, 32'h0000_2000, 24'h00_0002, fcd_pkg::SZ_WORD, fcd_pkg::RQ_AUTO);
    wdone(4'h1);
    for (i = 0; i < 2; i++) begin
      cyc(1'b0, 32'h0000_1000 + 4 * i, 0, 0);
      cyc(1'b1, 32'h0000_2000 + 4 * i, fd(32'h0000_1000 + 4 * i), 1);
    end
    chk(32'h0000_0000, 32'(remaining_count[0]));
    chk(32'h0000_1008, source_pointer[0]);
    chk(32'h0000_2008, destination_pointer[0]);
    chk(32'h0000_0001, 32'(dma_irq));
    ch_done_clear = 4'h1;
    @(negedge core_clk);
    ch_done_clear = 4'h0;
    chk(32'h0000_0000, 32'(dma_irq));
    // 16-byte unit at a high address with a slow memory
    slow = 4'h3;
    go(1, 32'hF000_0010, 32'hE000_0020, 24'h00_0001, fcd_pkg::SZ_BLK16, fcd_pkg::RQ_AUTO);
    wdone(4'h2);
    for (i = 0; i < 4; i++) cyc(1'b0, 32'hF000_0010 + 4 * i, 0, 0);
    for (i = 0; i < 4; i++) cyc(1'b1, 32'hE000_0020 + 4 * i, fd(32'hF000_0010 + 4 * i), 1);
    chk(32'h0000_0000, 32'(remaining_count[1]));
    chk(32'hF000_0020, source_pointer[1]);
    slow = 4'h0;
    ch3_indirect = 1'b1;
    go(3, 32'h0000_3000, 32'h0000_9000, 24'h00_0001, fcd_pkg::SZ_WORD, fcd_pkg::RQ_AUTO);
    wdone(4'h8);
    cyc(1'b0, 32'h0000_3000, 0, 0);
    cyc(1'b0, 32'h0000_3002, 0, 0);
    cyc(1'b0, 32'h3000_3002, 0, 0);
    cyc(1'b1, 32'h0000_9000, fd(32'h3000_3002), 1);
    chk(32'h0000_3004, source_pointer[3]);
    ch3_indirect = 1'b0;
    ch2_reload = 1'b1;
    go(2, 32'h0000_4000, 32'h0000_5000, 24'h00_0005, fcd_pkg::SZ_BYTE, fcd_pkg::RQ_AUTO);
    wdone(4'h4);
    for (i = 0; i < 5; i++) begin
      cyc(1'b0, 32'h0000_4000 + i % 4, 0, 0);
      cyc(1'b1, 32'h0000_5000 + i, 0, 0);
    end
    chk(32'h0000_000A, sz);
    ch2_reload = 1'b0;
    pk = 0;
    periph_req[2] = 1'b1;
    go(2, 32'h0000_4100, 32'h0000_5100, 24'h00_0001, fcd_pkg::SZ_WORD, fcd_pkg::RQ_PERIPH);
    wdone(4'h4);
    periph_req[2] = 1'b0;
    cyc(1'b0, 32'h0000_4100, 0, 0);
    cyc(1'b1, 32'h0000_5100, fd(32'h0000_4100), 1);
    chk(32'h0000_0001, pk);
    pri(1'b0, 1'b0, 4'b1100);
    pri(1'b0, 1'b1, 4'b1010);
    pri(1'b1, 1'b1, 4'b1100);
    // single address: ch0 level into memory, ch1 falling edge out of memory
    for (i = 0; i < 2; i++) begin
      ch_single[i] = 1'b1;
      ch_single_to_mem[i] = !i[0];
      ext_edge_mode[i] = i[0];
      tk = 0;
      sb = 0;
      go(i, 32'h0000_A000, 32'h0000_B000, 24'h00_0001, fcd_pkg::SZ_WORD, fcd_pkg::RQ_EXT);
      {ext_xfer_request_ch1_n, ext_xfer_request_ch0_n} = ~(2'h1 << i);
      wdone(4'h1 << i);
      {ext_xfer_request_ch1_n, ext_xfer_request_ch0_n} = 2'h3;
      cyc(!i[0], i[0] ? 32'h0000_A000 : 32'h0000_B000, 0, 0);
      chk(32'h0000_0000, q.size());
      chk(32'h0000_0001, tk);
      chk(32'h0000_0001, 32'(sb != 0));
      ch_single[i] = 1'b0;
    end
    // zero count means the maximum; a reset stops it mid-run
    go(0, 32'h0000_6000, 32'h0000_7000, 24'h00_0000, fcd_pkg::SZ_WORD, fcd_pkg::RQ_AUTO);
    for (k = 0; k < 50 && remaining_count[0] === 24'h00_0000; k++) @(negedge core_clk);
    chk(32'h00FF_FFFF, 32'(remaining_count[0]));
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk(32'h0000_0000, 32'(ch_active));
    chk(32'h0000_0000, 32'(remaining_count[0]));
    complete_run();
  end
endmodule // fcd_dma_tb
